// ==== logic/flash_regs_pkg.sv ====
// constants, field layouts and bus carriers for the flash clock/security bank
package flash_regs_pkg;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned IDX_W    = 4;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned NUM_REGS = 16;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CLKDIV   = 4'h0;
  localparam logic [IDX_W-1:0] IDX_SECURITY = 4'h1;
  localparam logic [IDX_W-1:0] IDX_RSVD_A   = 4'h2;
  localparam logic [IDX_W-1:0] IDX_CONFIG   = 4'h3;
  localparam logic [IDX_W-1:0] IDX_PROTECT  = 4'h4;
  localparam logic [IDX_W-1:0] IDX_STATUS   = 4'h5;
  localparam logic [IDX_W-1:0] IDX_COMMAND  = 4'h6;
  localparam logic [IDX_W-1:0] IDX_RSVD_B   = 4'h7;
  localparam logic [IDX_W-1:0] IDX_T_ADDR_H = 4'h8;
  localparam logic [IDX_W-1:0] IDX_T_ADDR_L = 4'h9;
  localparam logic [IDX_W-1:0] IDX_T_DATA_H = 4'hA;
  localparam logic [IDX_W-1:0] IDX_T_DATA_L = 4'hB;
  localparam logic [IDX_W-1:0] IDX_RSVD_C   = 4'hC;
  localparam logic [IDX_W-1:0] IDX_RSVD_D   = 4'hD;

  localparam int unsigned DIVIDE_W     = 6;
  localparam int unsigned PRESCALE_W   = 3;
  localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = 3'h7;

  localparam int unsigned CFG_BUF_EMPTY_BIT = 7;
  localparam int unsigned CFG_COMPLETE_BIT  = 6;
  localparam int unsigned CFG_KEY_ACCESS_BIT_BIT    = 5;

  localparam logic [1:0] KEYEN_ENABLED  = 2'h2;
  localparam logic [1:0] SEC_UNSECURED  = 2'h2;

  localparam logic [BYTE_W-1:0] CLKDIV_RESET   = 8'h00;
  localparam logic [BYTE_W-1:0] SECURITY_RESET = 8'h41;
  localparam logic [BYTE_W-1:0] ZERO_BYTE      = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              loaded;
    logic              prescale_by_eight;
    logic [DIVIDE_W-1:0] divide_value;
  } clkdiv_t;

  typedef struct packed {
    logic [1:0] backdoor_enable_field;
    logic [3:0] user_nv_flags;
    logic [1:0] security_field;
  } security_t;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axi_req_t;

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0]        rresp;
  } axi_rsp_t;

  typedef enum logic {LOAD_PENDING, LOAD_DONE} load_state_t;

endpackage

// ==== logic/flash_clock_security_regs.sv ====
// flash clock divider, security and configuration register bank on AXI4-Lite
`timescale 1ns/1ps
module flash_clock_security_regs
  import flash_regs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire axi_req_t    axi_req,
  output axi_rsp_t         axi_rsp,
  input  wire logic        osc_tick,
  input  wire logic [7:0]  config_security_byte,
  input  wire logic        backdoor_unlock,
  output logic             timing_tick,
  output security_t        security_state,
  output logic             backdoor_enabled,
  output logic             unsecured,
  output logic             buffer_empty_irq_en,
  output logic             complete_irq_en,
  output logic             key_access_bit
);

  axi_rsp_t          rsp_q;
  logic              aw_held_q;
  logic              w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [BYTE_W-1:0] wbyte_q;
  logic              wlane_q;
  clkdiv_t           clkdiv_q;
  security_t         security_q;
  load_state_t       load_state_q;
  logic              buf_irq_q;
  logic              cmp_irq_q;
  logic              key_access_bit_q;
  logic [PRESCALE_W-1:0] pre_cnt_q;
  logic [DIVIDE_W-1:0]   div_cnt_q;
  logic              tick_q;
  logic              bken_q;
  logic              unsec_q;
  logic [IDX_W-1:0]  rd_idx_q;

  // write channel handshakes
  logic              aw_take;
  logic              w_take;
  logic              wr_fire;
  logic              aw_held_d;
  logic              w_held_d;
  logic [IDX_W-1:0]  wr_idx;
  logic              wr_mapped;
  logic              wr_en;
  logic              wr_clkdiv;
  logic              wr_config;
  logic              wr_security;

  assign aw_take   = axi_req.awvalid & rsp_q.awready;
  assign w_take    = axi_req.wvalid & rsp_q.wready;
  assign wr_fire   = aw_held_q & w_held_q & ~rsp_q.bvalid;
  assign aw_held_d = (aw_held_q & ~wr_fire) | aw_take;
  assign w_held_d  = (w_held_q & ~wr_fire) | w_take;
  assign wr_idx    = awaddr_q[IDX_LSB +: IDX_W];
  assign wr_mapped = (awaddr_q[ADDR_W-1:IDX_LSB+IDX_W] == '0);
  assign wr_en     = wr_fire & wr_mapped & wlane_q;
  assign wr_clkdiv   = wr_en & (wr_idx == IDX_CLKDIV);
  assign wr_config   = wr_en & (wr_idx == IDX_CONFIG);
  assign wr_security = wr_en & (wr_idx == IDX_SECURITY);

  // read channel handshakes
  logic              ar_take;
  logic              rvalid_d;
  logic [IDX_W-1:0]  rd_idx;
  logic              rd_mapped;
  logic [BYTE_W-1:0] rd_byte;
  logic [BYTE_W-1:0] reg_view [NUM_REGS];

  assign ar_take   = axi_req.arvalid & rsp_q.arready;
  assign rvalid_d  = ar_take | (rsp_q.rvalid & ~axi_req.rready);
  assign rd_idx    = axi_req.araddr[IDX_LSB +: IDX_W];
  assign rd_mapped = (axi_req.araddr[ADDR_W-1:IDX_LSB+IDX_W] == '0);
  assign rd_byte   = rd_mapped ? reg_view[rd_idx] : ZERO_BYTE;

  // reserved, test and out-of-scope registers read as zero
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      reg_view[i] = ZERO_BYTE;
    end
    reg_view[IDX_CLKDIV]   = clkdiv_q;
    reg_view[IDX_SECURITY] = security_q;
    reg_view[IDX_CONFIG]   = {buf_irq_q, cmp_irq_q, key_access_bit_q, 5'h00};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wbyte_q   <= ZERO_BYTE;
      wlane_q   <= 1'b0;
    end else begin
      aw_held_q <= aw_held_d;
      w_held_q  <= w_held_d;
      if (aw_take) begin
        awaddr_q <= axi_req.awaddr;
      end
      if (w_take) begin
        wbyte_q <= axi_req.wdata[BYTE_W-1:0];
        wlane_q <= axi_req.wstrb[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rsp_q    <= '0;
      rd_idx_q <= '0;
    end else begin
      rsp_q.awready <= ~aw_held_d;
      rsp_q.wready  <= ~w_held_d;
      rsp_q.bvalid  <= wr_fire | (rsp_q.bvalid & ~axi_req.bready);
      if (wr_fire) begin
        rsp_q.bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      rsp_q.arready <= ~rvalid_d;
      rsp_q.rvalid  <= rvalid_d;
      if (ar_take) begin
        rsp_q.rdata <= {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
        rsp_q.rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        rd_idx_q    <= rd_idx;
      end
    end
  end

  // divider setting is write once; loaded flag only ever set by hardware
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clkdiv_q <= CLKDIV_RESET;
    end else if (wr_clkdiv && !clkdiv_q.loaded) begin
      clkdiv_q.prescale_by_eight <= wbyte_q[DIVIDE_W];
      clkdiv_q.divide_value      <= wbyte_q[DIVIDE_W-1:0];
      clkdiv_q.loaded            <= 1'b1;
    end
  end

  // security byte captured on the first edge after reset release
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      load_state_q <= LOAD_PENDING;
      security_q   <= SECURITY_RESET;
    end else begin
      case (load_state_q)
        LOAD_PENDING: begin
          security_q   <= config_security_byte;
          load_state_q <= LOAD_DONE;
        end
        LOAD_DONE: begin
          if (backdoor_unlock) begin
            security_q.security_field <= SEC_UNSECURED;
          end
        end
        default: begin
          load_state_q <= LOAD_PENDING;
        end
      endcase
    end
  end

  // decoded security status, held in flops for the outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      bken_q  <= 1'b0;
      unsec_q <= 1'b0;
    end else begin
      bken_q  <= (security_q.backdoor_enable_field == KEYEN_ENABLED);
      unsec_q <= (security_q.security_field == SEC_UNSECURED);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      buf_irq_q <= 1'b0;
      cmp_irq_q <= 1'b0;
      key_access_bit_q  <= 1'b0;
    end else if (wr_config) begin
      buf_irq_q <= wbyte_q[CFG_BUF_EMPTY_BIT];
      cmp_irq_q <= wbyte_q[CFG_COMPLETE_BIT];
      if (security_q.backdoor_enable_field == KEYEN_ENABLED) begin
        key_access_bit_q <= wbyte_q[CFG_KEY_ACCESS_BIT_BIT];
      end
    end
  end

  // timing tick: optional /8 then /(divide_value+1), max ratio 8*64
  logic pre_tick;
  logic div_wrap;

  assign pre_tick = clkdiv_q.prescale_by_eight ?
                    (osc_tick & (pre_cnt_q == PRESCALE_LAST)) :
                    osc_tick;
  assign div_wrap = (div_cnt_q == clkdiv_q.divide_value);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pre_cnt_q <= '0;
      div_cnt_q <= '0;
      tick_q    <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (clkdiv_q.loaded && osc_tick) begin
        pre_cnt_q <= pre_cnt_q + 1'b1;
      end
      if (clkdiv_q.loaded && pre_tick) begin
        if (div_wrap) begin
          div_cnt_q <= '0;
          tick_q    <= 1'b1;
        end else begin
          div_cnt_q <= div_cnt_q + 1'b1;
        end
      end
    end
  end

  assign axi_rsp             = rsp_q;
  assign timing_tick         = tick_q;
  assign security_state      = security_q;
  assign backdoor_enabled    = bken_q;
  assign unsecured           = unsec_q;
  assign buffer_empty_irq_en = buf_irq_q;
  assign complete_irq_en     = cmp_irq_q;
  assign key_access_bit      = key_access_bit_q;

  chk_loaded_sticky: assert property (
    @(posedge clk) disable iff (!rst_b)
    $past(clkdiv_q.loaded) |-> clkdiv_q.loaded)
    else $error("divider loaded flag dropped");

  chk_divider_once: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_clkdiv && clkdiv_q.loaded) |=> $stable(clkdiv_q))
    else $error("divider changed by a second write");

  chk_divider_first: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_clkdiv && !clkdiv_q.loaded) |=>
      (clkdiv_q.loaded &&
       clkdiv_q.divide_value == $past(wbyte_q[DIVIDE_W-1:0])))
    else $error("first divider write not taken");

  chk_security_load: assert property (
    @(posedge clk) disable iff (!rst_b)
    (load_state_q == LOAD_PENDING) |=>
      (security_q == $past(config_security_byte)) &&
      (load_state_q == LOAD_DONE))
    else $error("security byte not captured after reset");

  chk_security_ro: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_security && load_state_q == LOAD_DONE && !backdoor_unlock)
      |=> $stable(security_q))
    else $error("security register changed by a write");

  chk_unlock_force: assert property (
    @(posedge clk) disable iff (!rst_b)
    (load_state_q == LOAD_DONE && backdoor_unlock) |=>
      (security_q.security_field == SEC_UNSECURED) ##1 unsec_q)
    else $error("backdoor unlock did not unsecure");

  chk_key_access_bit_gate: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_config && security_q.backdoor_enable_field != KEYEN_ENABLED)
      |=> $stable(key_access_bit_q))
    else $error("key access written while backdoor disabled");

  chk_reserved_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    (rsp_q.rvalid && rd_idx_q == IDX_RSVD_A) |-> (rsp_q.rdata == '0))
    else $error("reserved register read nonzero");

  chk_divider_bound: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkdiv_q.loaded && pre_tick && div_wrap) |=>
      (tick_q && div_cnt_q == '0))
    else $error("divider wrap did not tick");

  chk_write_answer: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_fire |=> (rsp_q.bvalid && rsp_q.awready && rsp_q.wready))
    else $error("write response not given");

  chk_loaded_cause: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!clkdiv_q.loaded && !wr_clkdiv) |=> !clkdiv_q.loaded)
    else $error("divider loaded flag set without a write");

  chk_tick_idle: assert property (
    @(posedge clk) disable iff (!rst_b)
    !clkdiv_q.loaded |=> !tick_q)
    else $error("timing tick before the divider was loaded");

  chk_count_range: assert property (
    @(posedge clk) disable iff (!rst_b)
    div_cnt_q <= clkdiv_q.divide_value)
    else $error("divider count passed the divide value");

  chk_prescale_step: assert property (
    @(posedge clk) disable iff (!rst_b)
    (clkdiv_q.loaded && osc_tick) |=>
      (pre_cnt_q == $past(pre_cnt_q) + 3'h1))
    else $error("prescale counter missed an oscillator tick");

  chk_upper_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    rsp_q.rvalid |-> (rsp_q.rdata[DATA_W-1:BYTE_W] == '0))
    else $error("read data above the byte lane not zero");

  chk_unmapped_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    (ar_take && !rd_mapped) |=>
      (rsp_q.rresp == RESP_SLVERR && rsp_q.rdata == '0))
    else $error("read outside the bank not refused");

  chk_test_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    (rsp_q.rvalid && rd_idx_q >= IDX_T_ADDR_H) |-> (rsp_q.rdata == '0))
    else $error("factory test register read nonzero");

  chk_config_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    wr_config |=>
      (buf_irq_q == $past(wbyte_q[CFG_BUF_EMPTY_BIT]) &&
       cmp_irq_q == $past(wbyte_q[CFG_COMPLETE_BIT])))
    else $error("interrupt enable bits not written");

  chk_key_access_bit_open: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_config && security_q.backdoor_enable_field == KEYEN_ENABLED)
      |=> (key_access_bit_q == $past(wbyte_q[CFG_KEY_ACCESS_BIT_BIT])))
    else $error("key access not written while backdoor enabled");

  chk_enable_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    bken_q ==
      ($past(security_q.backdoor_enable_field) == KEYEN_ENABLED))
    else $error("backdoor enable decode wrong");

  chk_secure_decode: assert property (
    @(posedge clk) disable iff (!rst_b)
    unsec_q == ($past(security_q.security_field) == SEC_UNSECURED))
    else $error("security state decode wrong");

  chk_nv_kept: assert property (
    @(posedge clk) disable iff (!rst_b)
    (load_state_q == LOAD_DONE) |=> $stable(security_q.user_nv_flags))
    else $error("user flags changed after the load");

  chk_enable_kept: assert property (
    @(posedge clk) disable iff (!rst_b)
    (load_state_q == LOAD_DONE) |=>
      $stable(security_q.backdoor_enable_field))
    else $error("backdoor enable field changed after the load");

endmodule

// ==== bench/tb_flash_clock_security_regs.sv ====
// self-checking bench for the flash clock, security and config registers
`timescale 1ns/1ps
module tb_flash_clock_security_regs;
  import flash_regs_pkg::*;

  `define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
    err_count++; end end

  logic        clk;
  logic        rst_b;
  axi_req_t    req;
  axi_rsp_t    rsp;
  logic        osc_tick;
  logic        osc_half;
  logic [7:0]  cfg_byte;
  logic        unlock;
  logic        tick;
  security_t   sec_state;
  logic        bd_en;
  logic        unsec;
  logic        irq_be;
  logic        irq_cc;
  logic        key_acc;
  int          err_count;
  int          n_compared;
  logic [1:0]  resp;
  logic [7:0]  rd;

  flash_clock_security_regs dut (
    .clk                  (clk),
    .rst_b                (rst_b),
    .axi_req              (req),
    .axi_rsp              (rsp),
    .osc_tick             (osc_tick),
    .config_security_byte (cfg_byte),
    .backdoor_unlock      (unlock),
    .timing_tick          (tick),
    .security_state       (sec_state),
    .backdoor_enabled     (bd_en),
    .unsecured            (unsec),
    .buffer_empty_irq_en  (irq_be),
    .complete_irq_en      (irq_cc),
    .key_access_bit       (key_acc)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // oscillator tick every cycle, or every second cycle once osc_half is set
  always @(posedge clk) begin
    osc_tick <= !osc_half || !osc_tick;
  end

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic hung();
    $display("wait limit reached t=%0t", $time);
    err_count++;
    results();
  endtask

  // ready and valid are sampled at the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
                        input logic [3:0] s);
    logic aw_ok;
    logic w_ok;
    int   n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    for (n = 0; !(aw_ok && w_ok); n++) begin
      if (n == 1000) hung();
      @(negedge clk);
      aw_ok = aw_ok | (req.awvalid & rsp.awready);
      w_ok = w_ok | (req.wvalid & rsp.wready);
      @(posedge clk);
      if (aw_ok) req.awvalid <= 1'b0;
      if (w_ok) req.wvalid <= 1'b0;
    end
    for (n = 0; n <= 1000; n++) begin
      if (n == 1000) hung();
      @(negedge clk);
      if (rsp.bvalid === 1'b1) break;
    end
    resp = rsp.bresp;
    @(posedge clk);
    req.bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (n = 0; n <= 1000; n++) begin
      if (n == 1000) hung();
      @(negedge clk);
      if (rsp.arready === 1'b1) break;
    end
    @(posedge clk);
    req.arvalid <= 1'b0;
    for (n = 0; n <= 1000; n++) begin
      if (n == 1000) hung();
      @(negedge clk);
      if (rsp.rvalid === 1'b1) break;
    end
    rd = rsp.rdata[7:0];
    resp = rsp.rresp;
    `CHK(rsp.rdata[31:8], 24'h000000)
    @(posedge clk);
    req.rready <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] i, input logic [7:0] d);
    axi_wr({2'b00, i, 2'b00}, d, 4'hF);
    `CHK(resp, RESP_OKAY)
  endtask

  task automatic rchk(input logic [3:0] i, input logic [7:0] e);
    axi_rd({2'b00, i, 2'b00});
    `CHK(rd, e)
  endtask

  // cycles between two consecutive timing ticks
  task automatic tick_gap(input int exp);
    int n;
    for (n = 0; n <= 1200; n++) begin
      if (n == 1200) hung();
      @(negedge clk);
      if (tick === 1'b1) break;
    end
    for (n = 1; n <= 1200; n++) begin
      if (n == 1200) hung();
      @(negedge clk);
      if (tick === 1'b1) break;
    end
    `CHK(n, exp)
  endtask

  task automatic do_reset(input logic [7:0] b);
    @(posedge clk);
    rst_b    <= 1'b0;
    cfg_byte <= b;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
  endtask

  initial begin
    rst_b = 1'b0;
    req = '0;
    osc_half = 1'b0;
    cfg_byte = 8'hB5;
    unlock = 1'b0;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (40) begin
      @(negedge clk);
      `CHK(tick, 1'b0)
    end
    rchk(IDX_SECURITY, 8'hB5);
    `CHK(sec_state, 8'hB5)
    `CHK(bd_en, 1'b1)
    `CHK(unsec, 1'b0)
    rchk(IDX_CLKDIV, CLKDIV_RESET);
    wr(IDX_CLKDIV, 8'h7F);
    rchk(IDX_CLKDIV, 8'hFF);
    wr(IDX_CLKDIV, 8'h00);
    rchk(IDX_CLKDIV, 8'hFF);
    tick_gap(512);
    wr(IDX_SECURITY, 8'h00);
    rchk(IDX_SECURITY, 8'hB5);
    wr(IDX_CONFIG, 8'hFF);
    rchk(IDX_CONFIG, 8'hE0);
    `CHK({irq_be, irq_cc, key_acc}, 3'h7)
    axi_wr({2'b00, IDX_CONFIG, 2'b00}, 8'h00, 4'h0);
    rchk(IDX_CONFIG, 8'hE0);
    for (int i = 2; i < 16; i++) begin
      if (i != 3) begin
        wr(4'(i), 8'hFF);
        rchk(4'(i), ZERO_BYTE);
      end
    end
    axi_wr(8'h40, 8'hFF, 4'hF);
    `CHK(resp, RESP_SLVERR)
    axi_rd(8'hC4);
    `CHK(resp, RESP_SLVERR)
    `CHK(rd, ZERO_BYTE)
    @(posedge clk);
    unlock <= 1'b1;
    @(posedge clk);
    unlock <= 1'b0;
    rchk(IDX_SECURITY, 8'hB6);
    `CHK(sec_state, 8'hB6)
    `CHK(unsec, 1'b1)
    for (int p = 0; p < 4; p++) begin
      do_reset({2'(p), 4'hA, ~2'(p)});
      rchk(IDX_SECURITY, {2'(p), 4'hA, ~2'(p)});
      `CHK(sec_state, {2'(p), 4'hA, ~2'(p)})
      `CHK(bd_en, (p == 2))
      `CHK(unsec, (p == 1))
    end
    rchk(IDX_CLKDIV, CLKDIV_RESET);
    wr(IDX_CLKDIV, 8'h02);
    rchk(IDX_CLKDIV, 8'h82);
    tick_gap(3);
    wr(IDX_CONFIG, 8'hFF);
    rchk(IDX_CONFIG, 8'hC0);
    `CHK(key_acc, 1'b0)
    // legal setting: 20 MHz oscillator, /8 then /16 gives 156.25 kHz
    do_reset(8'hB5);
    osc_half <= 1'b1;
    wr(IDX_CLKDIV, 8'h4F);
    rchk(IDX_CLKDIV, 8'hCF);
    tick_gap(256);
    results();
  end

endmodule
